// >>> hdl/mpio_pkg.sv
`default_nettype none
package mpio_pkg;
    localparam logic [7:0] MPIO_OFS_PC_DATA = 8'h00;
    localparam logic [7:0] MPIO_OFS_PC_DIR  = 8'h01;
    localparam logic [7:0] MPIO_OFS_PD_DATA = 8'h02;
    localparam logic [7:0] MPIO_OFS_PD_DIR  = 8'h03;
    localparam logic [7:0] MPIO_OFS_PE_DATA = 8'h04;
    localparam logic [7:0] MPIO_OFS_PF_DATA = 8'h05;
    localparam logic [7:0] MPIO_OFS_PF_DIR  = 8'h06;
    localparam logic [7:0] MPIO_OFS_PG_DATA = 8'h07;
    localparam logic [7:0] MPIO_OFS_PG_DIR  = 8'h08;
    localparam logic [7:0] MPIO_OFS_PH_DATA = 8'h09;
    localparam logic [7:0] MPIO_OFS_PH_DIR  = 8'h0A;
    localparam logic [7:0] MPIO_OFS_ODSEL   = 8'h0B;
    localparam logic [7:0] MPIO_OFS_PULLUP  = 8'h0C;
    localparam logic [7:0] MPIO_OFS_WAKE    = 8'h0D;
    localparam logic [7:0] MPIO_OFS_LCD     = 8'h2D;

    localparam int MPIO_OD_THIRD = 0;
    localparam int MPIO_OD_SPI1  = 1;
    localparam int MPIO_OD_SCI1  = 2;
    localparam int MPIO_OD_SPI2  = 3;
    localparam int MPIO_OD_SCI2  = 4;
    localparam int MPIO_OD_MODE  = 6;
    localparam int MPIO_PU_F     = 0;
    localparam int MPIO_PU_G     = 1;
    localparam int MPIO_PU_H     = 2;
    localparam int MPIO_LCD_EN   = 0;
    localparam int MPIO_LCD_CK   = 1;
    localparam int MPIO_LCD_SEG  = 4;

    localparam logic [7:0] MPIO_RST_BYTE    = 8'h00;
    localparam int         MPIO_FAST_DIV    = 262144;
    localparam int         MPIO_PLL_DIV     = 8;
    localparam logic [1:0] MPIO_STRAP_BOOT  = 2'h0;
    localparam logic [1:0] MPIO_STRAP_TEST  = 2'h1;
    localparam logic [1:0] MPIO_STRAP_SINGL = 2'h2;
    localparam logic [1:0] MPIO_STRAP_EXP   = 2'h3;
    localparam logic [1:0] MPIO_STRAP_WAIT  = 2'h3;

    typedef enum logic [1:0] {
        MPIO_MODE_SINGLE,
        MPIO_MODE_EXP,
        MPIO_MODE_BOOT,
        MPIO_MODE_TEST
    } mpio_mode_t;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe_n;
    } mpio_pin8_t;
endpackage : mpio_pkg
`default_nettype wire

// >>> hdl/mpio_sync.sv
`default_nettype none
module mpio_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : mpio_sync
`default_nettype wire

// >>> hdl/mpio_top.sv
`default_nettype none
module mpio_top #(
    parameter int LCD_FAST_DIV = mpio_pkg::MPIO_FAST_DIV,
    parameter int LCD_PLL_DIV  = mpio_pkg::MPIO_PLL_DIV
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output var  logic [7:0]         reg_rdata,
    input  wire logic [1:0]         mode_sel_i,
    input  wire logic               pll_supply_enable,
    input  wire logic               timer_a_underflow_clock,
    input  wire logic [7:0]         ext_addr_lo,
    input  wire logic [7:0]         ext_wdata,
    input  wire logic               ext_data_drive,
    input  wire logic               ext_read_cycle,
    output var  logic [7:0]         ext_rdata,
    input  wire logic [7:0]         pc_i,
    output var  mpio_pkg::mpio_pin8_t pc_out,
    input  wire logic [5:0]         pd_i,
    output var  mpio_pkg::mpio_pin8_t pd_out,
    input  wire logic [5:0]         pd_alt_en,
    input  wire logic [5:0]         pd_alt_o,
    input  wire logic [5:0]         pd_alt_drive,
    output var  logic [5:0]         pd_level,
    input  wire logic [7:0]         pe_i,
    output var  logic [7:0]         pe_level,
    input  wire logic [7:0]         pf_i,
    output var  mpio_pkg::mpio_pin8_t pf_out,
    input  wire logic [7:0]         pg_i,
    output var  mpio_pkg::mpio_pin8_t pg_out,
    input  wire logic [5:0]         pg_alt_en,
    input  wire logic [5:0]         pg_alt_o,
    input  wire logic [5:0]         pg_alt_drive,
    output var  logic [5:0]         pg_level,
    input  wire logic [7:0]         ph_i,
    output var  mpio_pkg::mpio_pin8_t ph_out,
    input  wire logic [3:0]         pwm_en,
    input  wire logic [3:0]         pwm_o,
    output var  logic [1:0]         ph_timer_clk,
    output var  logic [3:0]         pb_seg_o,
    output var  logic [3:0]         pb_seg_oe_n,
    output var  logic               pb_lcd_own,
    output var  logic [2:0]         pullup_en,
    output var  logic               wake_irq
);
    localparam int FW = $clog2(LCD_FAST_DIV);
    localparam int PW = $clog2(LCD_PLL_DIV);

    logic [47:0]          sync_q;
    logic [7:0]           pc_s, pe_s, pf_s, pg_s, ph_s;
    logic [5:0]           pd_s;
    logic [1:0]           strap_s;
    mpio_pkg::mpio_mode_t mode_q;
    logic [1:0]           strap_cnt_q;
    logic [7:0]           lat_c_q, dir_c_q, lat_d_q, dir_d_q, lat_f_q, dir_f_q;
    logic [7:0]           lat_g_q, dir_g_q, lat_h_q, dir_h_q;
    logic [7:0]           odsel_q, pullup_q, wake_en_q;
    logic [3:0]           seg_q;
    logic                 ck_q, lcd_en_q, lcd_seen_q, bp_q;
    logic [FW-1:0]        fast_cnt_q;
    logic [PW-1:0]        pll_cnt_q;
    logic                 bus_mode, od_c_eff, od_dg_ok, bp_vis, lcd_tick;
    logic [7:0]           rd_d, pd_rb, pg_rb;
    mpio_pkg::mpio_pin8_t pc_d, pd_d, pf_d, pg_d, ph_d;

    mpio_sync #(.W(48)) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({mode_sel_i, ph_i, pg_i, pf_i, pe_i, pd_i, pc_i}),
        .q       (sync_q)
    );
    assign {strap_s, ph_s, pg_s, pf_s, pe_s, pd_s, pc_s} = sync_q;

    // Pin drive with optional open drain: a one floats, a zero pulls low
    function automatic logic [1:0] pin_drv(input logic en, input logic val,
                                           input logic od);
        pin_drv = {val, ~(en & (~od | ~val))};
    endfunction : pin_drv

    function automatic mpio_pkg::mpio_mode_t strap_mode(input logic [1:0] s);
        case (s)
            mpio_pkg::MPIO_STRAP_BOOT:  strap_mode = mpio_pkg::MPIO_MODE_BOOT;
            mpio_pkg::MPIO_STRAP_TEST:  strap_mode = mpio_pkg::MPIO_MODE_TEST;
            mpio_pkg::MPIO_STRAP_EXP:   strap_mode = mpio_pkg::MPIO_MODE_EXP;
            default:                    strap_mode = mpio_pkg::MPIO_MODE_SINGLE;
        endcase
    endfunction : strap_mode

    // Mode strap caught once the synchroniser has settled after release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_cnt_q <= '0;
            mode_q      <= mpio_pkg::MPIO_MODE_SINGLE;
        end else if (strap_cnt_q != mpio_pkg::MPIO_STRAP_WAIT) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == mpio_pkg::MPIO_STRAP_WAIT - 2'h1) begin
                mode_q <= strap_mode(strap_s);
            end
        end
    end

    assign bus_mode = (mode_q == mpio_pkg::MPIO_MODE_EXP) ||
                      (mode_q == mpio_pkg::MPIO_MODE_TEST);
    assign od_c_eff = odsel_q[mpio_pkg::MPIO_OD_THIRD] &&
                      (mode_q == mpio_pkg::MPIO_MODE_SINGLE);
    assign od_dg_ok = (mode_q == mpio_pkg::MPIO_MODE_SINGLE) ||
                      (mode_q == mpio_pkg::MPIO_MODE_EXP);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lat_c_q   <= mpio_pkg::MPIO_RST_BYTE;
            dir_c_q   <= mpio_pkg::MPIO_RST_BYTE;
            lat_d_q   <= mpio_pkg::MPIO_RST_BYTE;
            dir_d_q   <= mpio_pkg::MPIO_RST_BYTE;
            lat_f_q   <= mpio_pkg::MPIO_RST_BYTE;
            dir_f_q   <= mpio_pkg::MPIO_RST_BYTE;
            lat_g_q   <= mpio_pkg::MPIO_RST_BYTE;
            dir_g_q   <= mpio_pkg::MPIO_RST_BYTE;
            lat_h_q   <= mpio_pkg::MPIO_RST_BYTE;
            dir_h_q   <= mpio_pkg::MPIO_RST_BYTE;
            odsel_q   <= mpio_pkg::MPIO_RST_BYTE;
            pullup_q  <= mpio_pkg::MPIO_RST_BYTE;
            wake_en_q <= mpio_pkg::MPIO_RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                mpio_pkg::MPIO_OFS_PC_DATA: lat_c_q   <= reg_wdata;
                mpio_pkg::MPIO_OFS_PC_DIR:  dir_c_q   <= reg_wdata;
                mpio_pkg::MPIO_OFS_PD_DATA: lat_d_q   <= {2'h0, reg_wdata[5:0]};
                mpio_pkg::MPIO_OFS_PD_DIR:  dir_d_q   <= {2'h0, reg_wdata[5:0]};
                mpio_pkg::MPIO_OFS_PF_DATA: lat_f_q   <= reg_wdata;
                mpio_pkg::MPIO_OFS_PF_DIR:  dir_f_q   <= reg_wdata;
                mpio_pkg::MPIO_OFS_PG_DATA: lat_g_q   <= reg_wdata;
                mpio_pkg::MPIO_OFS_PG_DIR:  dir_g_q   <= reg_wdata;
                mpio_pkg::MPIO_OFS_PH_DATA: lat_h_q   <= reg_wdata;
                mpio_pkg::MPIO_OFS_PH_DIR:  dir_h_q   <= reg_wdata;
                mpio_pkg::MPIO_OFS_ODSEL:   odsel_q   <= {3'h0, reg_wdata[4:0]};
                mpio_pkg::MPIO_OFS_PULLUP:  pullup_q  <= {5'h0, reg_wdata[2:0]};
                mpio_pkg::MPIO_OFS_WAKE:    wake_en_q <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // Segment register; the enable bit is locked after the first write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seg_q      <= '0;
            ck_q       <= 1'b0;
            lcd_en_q   <= 1'b0;
            lcd_seen_q <= 1'b0;
        end else if (reg_wr && reg_addr == mpio_pkg::MPIO_OFS_LCD) begin
            seg_q      <= reg_wdata[mpio_pkg::MPIO_LCD_SEG +: 4];
            ck_q       <= reg_wdata[mpio_pkg::MPIO_LCD_CK];
            lcd_seen_q <= 1'b1;
            if (!lcd_seen_q) begin
                lcd_en_q <= reg_wdata[mpio_pkg::MPIO_LCD_EN];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fast_cnt_q <= '0;
        end else if (fast_cnt_q == FW'(LCD_FAST_DIV - 1)) begin
            fast_cnt_q <= '0;
        end else begin
            fast_cnt_q <= fast_cnt_q + FW'(1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pll_cnt_q <= '0;
        end else if (timer_a_underflow_clock) begin
            pll_cnt_q <= pll_cnt_q + PW'(1);
        end
    end

    always_comb begin
        if (!ck_q) begin
            lcd_tick = timer_a_underflow_clock;
        end else if (pll_supply_enable) begin
            lcd_tick = timer_a_underflow_clock &&
                       (pll_cnt_q == PW'(LCD_PLL_DIV - 1));
        end else begin
            lcd_tick = (fast_cnt_q == FW'(LCD_FAST_DIV - 1));
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bp_q <= 1'b0;
        end else if (lcd_en_q && lcd_tick) begin
            bp_q <= ~bp_q;
        end
    end

    assign bp_vis = bp_q & (|seg_q);

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (bus_mode) begin
                {pc_d.o[i], pc_d.oe_n[i]} = pin_drv(ext_data_drive, ext_wdata[i], 1'b0);
                {pf_d.o[i], pf_d.oe_n[i]} = pin_drv(1'b1, ext_addr_lo[i], 1'b0);
            end else begin
                {pc_d.o[i], pc_d.oe_n[i]} = pin_drv(dir_c_q[i], lat_c_q[i], od_c_eff);
                {pf_d.o[i], pf_d.oe_n[i]} = pin_drv(dir_f_q[i], lat_f_q[i], 1'b0);
            end
            if (i < 4 && pwm_en[i[1:0]]) begin
                {ph_d.o[i], ph_d.oe_n[i]} = pin_drv(1'b1, pwm_o[i[1:0]], 1'b0);
            end else begin
                {ph_d.o[i], ph_d.oe_n[i]} = pin_drv(dir_h_q[i], lat_h_q[i], 1'b0);
            end
        end
        for (int i = 0; i < 6; i++) begin
            if (pd_alt_en[i]) begin
                {pd_d.o[i], pd_d.oe_n[i]} = pin_drv(pd_alt_drive[i], pd_alt_o[i],
                    od_dg_ok & odsel_q[i < 2 ? mpio_pkg::MPIO_OD_SCI1 : mpio_pkg::MPIO_OD_SPI1]);
            end else begin
                {pd_d.o[i], pd_d.oe_n[i]} = pin_drv(dir_d_q[i], lat_d_q[i],
                    od_dg_ok & odsel_q[i < 2 ? mpio_pkg::MPIO_OD_SCI1 : mpio_pkg::MPIO_OD_SPI1]);
            end
            if (pg_alt_en[i]) begin
                {pg_d.o[i], pg_d.oe_n[i]} = pin_drv(pg_alt_drive[i], pg_alt_o[i],
                    od_dg_ok & odsel_q[i < 2 ? mpio_pkg::MPIO_OD_SCI2 : mpio_pkg::MPIO_OD_SPI2]);
            end else begin
                {pg_d.o[i], pg_d.oe_n[i]} = pin_drv(dir_g_q[i], lat_g_q[i],
                    od_dg_ok & odsel_q[i < 2 ? mpio_pkg::MPIO_OD_SCI2 : mpio_pkg::MPIO_OD_SPI2]);
            end
        end
        pd_d.o[7:6]    = 2'h0;
        pd_d.oe_n[7:6] = 2'h3;
        if (lcd_en_q) begin
            {pg_d.o[6], pg_d.oe_n[6]} = pin_drv(1'b1, bp_vis, 1'b0);
        end else begin
            {pg_d.o[6], pg_d.oe_n[6]} = pin_drv(dir_g_q[6] & ~bus_mode, lat_g_q[6], 1'b0);
        end
        if (bus_mode) begin
            {pg_d.o[7], pg_d.oe_n[7]} = pin_drv(1'b1, ext_read_cycle, 1'b0);
        end else begin
            {pg_d.o[7], pg_d.oe_n[7]} = pin_drv(dir_g_q[7], lat_g_q[7], 1'b0);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_out      <= '{o: 8'h00, oe_n: 8'hFF};
            pd_out      <= '{o: 8'h00, oe_n: 8'hFF};
            pf_out      <= '{o: 8'h00, oe_n: 8'hFF};
            pg_out      <= '{o: 8'h00, oe_n: 8'hFF};
            ph_out      <= '{o: 8'h00, oe_n: 8'hFF};
            pb_seg_o    <= 4'h0;
            pb_seg_oe_n <= 4'hF;
            pb_lcd_own  <= 1'b0;
        end else begin
            pc_out      <= pc_d;
            pd_out      <= pd_d;
            pf_out      <= pf_d;
            pg_out      <= pg_d;
            ph_out      <= ph_d;
            pb_seg_o    <= {4{bp_vis}} ^ seg_q;
            pb_seg_oe_n <= {4{~lcd_en_q}};
            pb_lcd_own  <= lcd_en_q;
        end
    end

    assign pd_rb = {2'h0, (dir_d_q[5:0] & lat_d_q[5:0]) | (~dir_d_q[5:0] & pd_s)};
    assign pg_rb = (dir_g_q & lat_g_q) | (~dir_g_q & pg_s);

    always_comb begin
        case (reg_addr)
            mpio_pkg::MPIO_OFS_PC_DATA: rd_d = pc_s;
            mpio_pkg::MPIO_OFS_PC_DIR:  rd_d = dir_c_q;
            mpio_pkg::MPIO_OFS_PD_DATA: rd_d = pd_rb;
            mpio_pkg::MPIO_OFS_PD_DIR:  rd_d = dir_d_q;
            mpio_pkg::MPIO_OFS_PE_DATA: rd_d = pe_s;
            mpio_pkg::MPIO_OFS_PF_DATA: rd_d = pf_s;
            mpio_pkg::MPIO_OFS_PF_DIR:  rd_d = dir_f_q;
            mpio_pkg::MPIO_OFS_PG_DATA: rd_d = pg_rb;
            mpio_pkg::MPIO_OFS_PG_DIR:  rd_d = dir_g_q;
            mpio_pkg::MPIO_OFS_PH_DATA: rd_d = ph_s;
            mpio_pkg::MPIO_OFS_PH_DIR:  rd_d = dir_h_q;
            mpio_pkg::MPIO_OFS_ODSEL:   rd_d = {mode_q, odsel_q[5:0]};
            mpio_pkg::MPIO_OFS_PULLUP:  rd_d = pullup_q;
            mpio_pkg::MPIO_OFS_WAKE:    rd_d = wake_en_q;
            mpio_pkg::MPIO_OFS_LCD:     rd_d = {seg_q, 2'h0, ck_q, lcd_en_q};
            default:                    rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_rdata    <= 8'h00;
            pd_level     <= 6'h00;
            pe_level     <= 8'h00;
            pg_level     <= 6'h00;
            ph_timer_clk <= 2'h0;
            pullup_en    <= 3'h0;
            wake_irq     <= 1'b0;
        end else begin
            ext_rdata    <= pc_s;
            pd_level     <= pd_s;
            pe_level     <= pe_s;
            pg_level     <= pg_s[5:0];
            ph_timer_clk <= ph_s[7:6];
            pullup_en    <= pullup_q[2:0];
            wake_irq     <= |(wake_en_q & ~ph_s);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence lcd_first_wr_s;
        reg_wr && reg_addr == mpio_pkg::MPIO_OFS_LCD && !lcd_seen_q;
    endsequence
    sequence lcd_late_wr_s;
        reg_wr && reg_addr == mpio_pkg::MPIO_OFS_LCD && lcd_seen_q;
    endsequence

    pc_read_pins_a: assert property (reg_rd && reg_addr == mpio_pkg::MPIO_OFS_PC_DATA
        |=> reg_rdata == $past(pc_s)) else $error("third port read not pin level");
    pc_bus_drive_a: assert property (bus_mode && ext_data_drive
        |=> !pc_out.oe_n[0] && pc_out.o == $past(ext_wdata)) else $error("data bus not driven");
    pc_od_float_a: assert property (!bus_mode && od_c_eff && dir_c_q[0] && lat_c_q[0]
        |=> pc_out.oe_n[0]) else $error("open drain one not floating");
    pc_od_mode_a: assert property (mode_q == mpio_pkg::MPIO_MODE_BOOT && dir_c_q[0]
        && lat_c_q[0] |=> !pc_out.oe_n[0]) else $error("open drain outside single chip");
    pd_readback_a: assert property (reg_rd && reg_addr == mpio_pkg::MPIO_OFS_PD_DATA
        |=> reg_rdata == $past(pd_rb)) else $error("fourth port readback wrong");
    lcd_lock_a: assert property (lcd_late_wr_s |=> lcd_en_q == $past(lcd_en_q))
        else $error("enable changed after first write");
    lcd_first_a: assert property (lcd_first_wr_s
        |=> lcd_en_q == $past(reg_wdata[mpio_pkg::MPIO_LCD_EN])) else $error("first write lost");
    bp_off_a: assert property (lcd_en_q && seg_q == 4'h0 |=> !pg_out.o[6])
        else $error("backplane not forced low");
    seg_phase_a: assert property (lcd_en_q
        |=> pb_seg_o == ({4{pg_out.o[6]}} ^ $past(seg_q))) else $error("segment phase wrong");
    bp_toggle_a: assert property (lcd_en_q && !ck_q && timer_a_underflow_clock
        |=> bp_q != $past(bp_q)) else $error("backplane missed underflow");
    bp_pll_div_a: assert property (lcd_en_q && ck_q && pll_supply_enable &&
        timer_a_underflow_clock && pll_cnt_q != PW'(LCD_PLL_DIV - 1)
        |=> bp_q == $past(bp_q)) else $error("divided source toggled early");
    rw_strobe_a: assert property (bus_mode
        |=> !pg_out.oe_n[7] && pg_out.o[7] == $past(ext_read_cycle)) else $error("strobe wrong");
    pf_addr_a: assert property (bus_mode |=> pf_out.o == $past(ext_addr_lo))
        else $error("low address not on sixth port");
    lcd_rsvd_a: assert property (reg_rd && reg_addr == mpio_pkg::MPIO_OFS_LCD
        |=> reg_rdata[3:2] == 2'h0) else $error("reserved bits not zero");
    wake_a: assert property ((wake_en_q & ~ph_s) != 8'h00 |=> wake_irq)
        else $error("wake interrupt missing");
endmodule : mpio_top
`default_nettype wire

// >>> verif/mpio_board.sv
`default_nettype none
module mpio_board (
    input  wire mpio_pkg::mpio_pin8_t pin,
    input  wire logic [7:0]           ext_v,
    input  wire logic [7:0]           ext_en,
    output var  logic [7:0]           lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // Wired-AND of both drivers; released lines are pulled high on the board
    always_comb begin
        lvl = (pin.oe_n | pin.o) & (~ext_en | ext_v);
    end
endmodule : mpio_board
`default_nettype wire

// >>> verif/mpio_top_test.sv
`default_nettype none
module mpio_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic [7:0]           reg_addr = 8'h00;
    logic [7:0]           reg_wdata = 8'h00;
    logic                 reg_wr = 1'b0;
    logic                 reg_rd = 1'b0;
    logic [1:0]           mode_sel_i = mpio_pkg::MPIO_STRAP_SINGL;
    logic                 tmr = 1'b0;
    logic                 rdc = 1'b0;
    logic [7:0]           alo = 8'h00;
    logic [7:0]           xv [5] = '{5{8'h00}};
    logic [7:0]           xe [5] = '{5{8'h00}};
    logic [7:0]           lv [5];
    mpio_pkg::mpio_pin8_t po [5];
    logic [7:0]           reg_rdata;
    logic [3:0]           pb_seg_o;
    logic                 pb_lcd_own;
    logic                 wake_irq;
    logic [2:0]           pullup_en;
    logic                 b;
    logic                 pll = 1'b0;
    logic                 xdd = 1'b0;
    logic [7:0]           xw = 8'h00;
    logic [7:0]           pe = 8'h00;
    logic [5:0]           alt = 6'h00;
    logic [3:0]           pwm = 4'h0;
    logic [7:0]           ext_rdata;
    logic [7:0]           pe_level;
    logic [5:0]           pd_level;
    logic [5:0]           pg_level;
    logic [3:0]           pb_seg_oe_n;
    logic [1:0]           ph_timer_clk;
    int                   mismatches = 0;
    int                   n_checks = 0;
    always #5 clk = ~clk;
    for (genvar i = 0; i < 5; i++) begin : g_pin
        mpio_board u_mpio_board (.pin(po[i]), .ext_v(xv[i]), .ext_en(xe[i]), .lvl(lv[i]));
    end
    mpio_top #(.LCD_FAST_DIV(16), .LCD_PLL_DIV(8)) u_mpio_top (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_sel_i(mode_sel_i),
        .pll_supply_enable(pll), .timer_a_underflow_clock(tmr), .ext_addr_lo(alo),
        .ext_wdata(xw), .ext_data_drive(xdd), .ext_read_cycle(rdc), .ext_rdata(ext_rdata),
        .pc_i(lv[0]), .pc_out(po[0]), .pd_i(lv[1][5:0]), .pd_out(po[1]),
        .pd_alt_en(alt), .pd_alt_o(6'h00), .pd_alt_drive(6'h00), .pd_level(pd_level),
        .pe_i(pe), .pe_level(pe_level), .pf_i(lv[2]), .pf_out(po[2]),
        .pg_i(lv[3]), .pg_out(po[3]),
        .pg_alt_en(alt), .pg_alt_o(6'h00), .pg_alt_drive(6'h00), .pg_level(pg_level),
        .ph_i(lv[4]), .ph_out(po[4]), .pwm_en(pwm), .pwm_o(pwm),
        .ph_timer_clk(ph_timer_clk), .pb_seg_o(pb_seg_o), .pb_seg_oe_n(pb_seg_oe_n),
        .pb_lcd_own(pb_lcd_own), .pullup_en(pullup_en), .wake_irq(wake_irq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd
    task automatic t_third();
        chk(po[0].oe_n, 8'hFF);
        chk({4'h0, pb_seg_oe_n}, 8'h0F);
        rd(8'h7F, 8'h00);
        wr(mpio_pkg::MPIO_OFS_PC_DATA, 8'h5A);
        wr(mpio_pkg::MPIO_OFS_PC_DIR, 8'hFF);
        xe[0] <= 8'hFF; xv[0] <= 8'h0F;
        cyc(4);
        chk(po[0].oe_n, 8'h00);
        rd(mpio_pkg::MPIO_OFS_PC_DATA, 8'h0A);
        wr(mpio_pkg::MPIO_OFS_ODSEL, 8'h01);
        xe[0] <= 8'h00;
        cyc(2);
        chk(po[0].oe_n, 8'h5A);
    endtask : t_third
    task automatic t_fourth();
        wr(mpio_pkg::MPIO_OFS_PD_DIR, 8'h0F);
        wr(mpio_pkg::MPIO_OFS_PD_DATA, 8'h05);
        xe[1] <= 8'hFF; xv[1] <= 8'h2A;
        cyc(4);
        rd(mpio_pkg::MPIO_OFS_PD_DATA, 8'h25);
        chk({2'h0, pd_level}, 8'h20);
        wr(mpio_pkg::MPIO_OFS_ODSEL, 8'h06);
        cyc(2);
        chk(po[1].oe_n, 8'hF5);
    endtask : t_fourth
    task automatic t_lcd();
        rd(mpio_pkg::MPIO_OFS_LCD, 8'h00);
        wr(mpio_pkg::MPIO_OFS_LCD, 8'h01);
        cyc(2);
        chk({7'h00, pb_lcd_own}, 8'h01);
        chk({4'h0, pb_seg_oe_n}, 8'h00);
        chk({6'h00, po[3].oe_n[6], po[3].o[6]}, 8'h00);
        wr(mpio_pkg::MPIO_OFS_LCD, 8'h3C);
        rd(mpio_pkg::MPIO_OFS_LCD, 8'h31);
        @(posedge clk);
        tmr <= 1'b1;
        @(posedge clk);
        tmr <= 1'b0;
        cyc(3);
        chk({7'h00, po[3].o[6]}, 8'h01);
        chk({4'h0, pb_seg_o}, 8'h0C);
        wr(mpio_pkg::MPIO_OFS_LCD, 8'h32);
        cyc(3);
        b = po[3].o[6];
        cyc(16);
        chk({7'h00, po[3].o[6]}, {7'h00, ~b});
        @(posedge clk);
        pll <= 1'b1;
        cyc(2);
        b = po[3].o[6];
        repeat (8) begin
            @(posedge clk);
            tmr <= 1'b1;
            @(posedge clk);
            tmr <= 1'b0;
        end
        cyc(3);
        chk({7'h00, po[3].o[6]}, {7'h00, ~b});
    endtask : t_lcd
    task automatic t_wake();
        wr(mpio_pkg::MPIO_OFS_PULLUP, 8'h07);
        wr(mpio_pkg::MPIO_OFS_WAKE, 8'h01);
        cyc(4);
        chk({7'h00, wake_irq}, 8'h00);
        @(posedge clk);
        pe <= 8'hC3;
        xe[4] <= 8'h41;
        cyc(4);
        chk({7'h00, wake_irq}, 8'h01);
        chk({5'h00, pullup_en}, 8'h07);
        chk({6'h00, ph_timer_clk}, 8'h02);
        chk(pe_level, 8'hC3);
        rd(mpio_pkg::MPIO_OFS_PE_DATA, 8'hC3);
    endtask : t_wake
    task automatic t_alt();
        wr(mpio_pkg::MPIO_OFS_PG_DIR, 8'h3F);
        cyc(4);
        chk({2'h0, pg_level}, 8'h00);
        @(posedge clk);
        alt <= 6'h3F;
        pwm <= 4'hA;
        cyc(4);
        chk(po[3].oe_n, 8'hBF);
        chk(po[1].oe_n, 8'hFF);
        chk({2'h0, pg_level}, 8'h3F);
        chk(po[4].o, 8'h0A);
        chk(po[4].oe_n, 8'hF5);
    endtask : t_alt
    task automatic rst_to(input logic [1:0] s);
        @(posedge clk);
        sys_rst <= 1'b1;
        mode_sel_i <= s;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(6);
    endtask : rst_to
    task automatic t_bus();
        @(posedge clk);
        alo <= 8'hA5;
        rdc <= 1'b1;
        rst_to(mpio_pkg::MPIO_STRAP_EXP);
        chk(po[2].o, 8'hA5);
        chk({7'h00, po[3].o[7]}, 8'h01);
        chk(po[0].oe_n, 8'hFF);
        rd(mpio_pkg::MPIO_OFS_ODSEL, 8'h40);
        @(posedge clk);
        xw <= 8'h3C;
        xdd <= 1'b1;
        rdc <= 1'b0;
        cyc(6);
        chk(po[0].o, 8'h3C);
        chk(po[0].oe_n, 8'h00);
        chk(ext_rdata, 8'h3C);
        chk({7'h00, po[3].o[7]}, 8'h00);
        wr(mpio_pkg::MPIO_OFS_LCD, 8'h00);
        wr(mpio_pkg::MPIO_OFS_LCD, 8'h01);
        cyc(2);
        chk({7'h00, pb_lcd_own}, 8'h00);
        chk({4'h0, pb_seg_oe_n}, 8'h0F);
    endtask : t_bus
    task automatic t_boot();
        rst_to(mpio_pkg::MPIO_STRAP_BOOT);
        rd(mpio_pkg::MPIO_OFS_ODSEL, 8'h80);
        wr(mpio_pkg::MPIO_OFS_ODSEL, 8'h01);
        wr(mpio_pkg::MPIO_OFS_PC_DATA, 8'hFF);
        wr(mpio_pkg::MPIO_OFS_PC_DIR, 8'hFF);
        cyc(2);
        chk(po[0].oe_n, 8'h00);
    endtask : t_boot
    task automatic tally_and_finish();
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(4);
        t_third();
        t_fourth();
        t_lcd();
        t_wake();
        t_alt();
        t_bus();
        t_boot();
        tally_and_finish();
    end
    initial begin
        #20us;
        mismatches++;
        tally_and_finish();
    end
endmodule : mpio_top_test
`default_nettype wire
